//--- include/bfq_pkg.sv
/*
 * constants for the two-way queue flag and port B control logic.
 * assumes one system clock; port clocks arrive as sampled levels.
 */
// Summary of operation
// (R1) port B transfers happen only while its active-low enable is low
// (R2) on a port B read, low output enable drives the B data bus
// (R3) A-to-B empty flag low on clock B when queue empty; B reads blocked
// (R4) bypass: A-to-B empty flag high while A data waits, low once B reads
// (R5) A-to-B almost-empty low while count at or below offset; offset resets to 8
// (R6) A-to-B almost-full low on clock A while count above depth minus offset
// (R7) A-to-B full flag low on clock A when queue full; A writes blocked
// (R8) bypass: A-to-B full low while message unread by B; A writes after read
// (R9) B-to-A empty flag low on clock A when queue empty; A reads blocked
// (R10) bypass: B-to-A empty high while B data waits, low cycle after A reads
// (R11) B-to-A almost-empty low on clock A while count at or below offset
// (R12) B-to-A almost-full low on clock B while count above depth minus offset
// (R13) B-to-A full flag low on clock B when queue full; B writes blocked
// (R14) bypass: B-to-A full low while message unread by A; B writes after read
// (R15) bypass indication on clock B low in bypass, high in queue mode
// (R16) active-low global reset clears queues, flags and offsets
// (R17) port B acts on clock B rising edge; direction low writes, high reads
// (R18) bypass: B write loads B-to-A register, B read takes A-to-B register
// (R19) after reset empty flags low, full flags high, bypass indication high
// (R20) each party checks full or empty before transferring and holds off

package bfq_pkg;

	localparam int DATA_W = 18;
	localparam int DEPTH  = 256;
	localparam int PTR_W  = 8;
	localparam int CNT_W  = 9;
	localparam int ADDR_W = 3;
	localparam int REG_W  = 9;

	localparam logic [CNT_W-1:0] DEPTH_CNT = 9'h100;
	localparam logic [REG_W-1:0] OFFSET_RST = 9'h008;

	// register map, word addresses on the plain register port
	localparam logic [ADDR_W-1:0] REG_AB_AE_OFF = 3'h0;
	localparam logic [ADDR_W-1:0] REG_AB_AF_OFF = 3'h1;
	localparam logic [ADDR_W-1:0] REG_BA_AE_OFF = 3'h2;
	localparam logic [ADDR_W-1:0] REG_BA_AF_OFF = 3'h3;
	localparam logic [ADDR_W-1:0] REG_CTRL      = 3'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 3'h5;

	localparam int CTRL_BYPASS_BIT = 0;

	// status register bit positions
	localparam int ST_AB_EMPTY  = 0;
	localparam int ST_AB_AEMPTY = 1;
	localparam int ST_AB_AFULL  = 2;
	localparam int ST_AB_FULL   = 3;
	localparam int ST_BA_EMPTY  = 4;
	localparam int ST_BA_AEMPTY = 5;
	localparam int ST_BA_AFULL  = 6;
	localparam int ST_BA_FULL   = 7;
	localparam int ST_BYP_IND   = 8;

	// direction encoding of both ports
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;

	// direction index: 0 is A-to-B, 1 is B-to-A; port index: 0 is A, 1 is B
	localparam int DIR_AB = 0;
	localparam int DIR_BA = 1;

endpackage : bfq_pkg

//--- logic/bfq_edge.sv
/*
 * rising-edge detector for a port clock sampled by the system clock.
 * assumes the port clock level is already synchronous to clk_sys_i.
 */
`timescale 1ns/100ps

module bfq_edge import bfq_pkg::*; (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic level_i,
	output logic      rise_o
);

	typedef struct packed {
		logic prev;
	} bfq_edge_s;

	bfq_edge_s state;
	bfq_edge_s next_state;

	always_comb begin
		next_state      = state;
		next_state.prev = level_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= '1;
		end else begin
			state <= next_state;
		end
	end

	// a port clock already high at reset release gives no edge
	assign rise_o = level_i & ~state.prev;

endmodule : bfq_edge

//--- logic/bfq_queue.sv
/*
 * one direction of the two-way queue: storage, count and four flags.
 * assumes write and read requests are single-cycle and tick-qualified.
 */
`timescale 1ns/100ps

module bfq_queue import bfq_pkg::*; (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	input  wire logic              wr_tick_i,
	input  wire logic              rd_tick_i,
	input  wire logic [DATA_W-1:0] data_i,
	input  wire logic [REG_W-1:0]  ae_off_i,
	input  wire logic [REG_W-1:0]  af_off_i,
	output logic                   wr_ok_o,
	output logic                   rd_ok_o,
	output logic [DATA_W-1:0]      head_o,
	output logic                   empty_n_o,
	output logic                   almost_empty_n_o,
	output logic                   full_n_o,
	output logic                   almost_full_n_o
);

	typedef struct packed {
		logic [PTR_W-1:0] wptr;
		logic [PTR_W-1:0] rptr;
		logic [CNT_W-1:0] count;
		logic             empty_n;
		logic             aempty_n;
		logic             full_n;
		logic             afull_n;
	} bfq_queue_s;

	bfq_queue_s        state;
	bfq_queue_s        next_state;
	logic [DATA_W-1:0] mem [DEPTH];

	// the flags alone gate requests: a flag can only be stale in the safe sense
	assign wr_ok_o = wr_i & state.full_n; // R7 R13
	assign rd_ok_o = rd_i & state.empty_n; // R3 R9
	assign head_o  = mem[state.rptr];

	always_comb begin
		next_state = state;
		if (wr_ok_o) begin
			next_state.wptr = state.wptr + 8'h01;
		end
		if (rd_ok_o) begin
			next_state.rptr = state.rptr + 8'h01;
		end
		case ({wr_ok_o, rd_ok_o})
			2'b10:   next_state.count = state.count + 9'h001;
			2'b01:   next_state.count = state.count - 9'h001;
			default: next_state.count = state.count;
		endcase
		// reader-side flags move only on the reader's clock edge
		if (rd_tick_i) begin
			next_state.empty_n  = (next_state.count != 9'h000); // R3 R9
			next_state.aempty_n = (next_state.count > ae_off_i); // R5 R11
		end
		// writer-side flags move only on the writer's clock edge
		if (wr_tick_i) begin
			next_state.full_n  = (next_state.count != DEPTH_CNT); // R7 R13
			next_state.afull_n = (next_state.count <= DEPTH_CNT - af_off_i); // R6 R12
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state         <= '0; // R16
			state.full_n  <= 1'b1; // R19
			state.afull_n <= 1'b1; // R19
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (wr_ok_o) begin
			mem[state.wptr] <= data_i;
		end
	end

	assign empty_n_o        = state.empty_n;
	assign almost_empty_n_o = state.aempty_n;
	assign full_n_o         = state.full_n;
	assign almost_full_n_o  = state.afull_n;

endmodule : bfq_queue

//--- logic/bfq_top.sv
/*
 * flag and port B control of a two-way queue with a bypass path.
 * holds both queue directions, the bypass message registers, the
 * offset and control registers and the port output registers.
 * assumes port clocks and all pins are synchronous to clk_sys_i and
 * that port clocks run well below half the system clock rate.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module bfq_top import bfq_pkg::*; (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              global_reset_n_i,
	input  wire logic              port_a_clk_i,
	input  wire logic              port_b_clk_i,
	input  wire logic              port_a_xfer_enable_n_i,
	input  wire logic              port_a_dir_i,
	input  wire logic [DATA_W-1:0] port_a_bus_i,
	output logic      [DATA_W-1:0] port_a_bus_o,
	input  wire logic              port_b_xfer_enable_n_i,
	input  wire logic              port_b_dir_i,
	input  wire logic              port_b_out_enable_n_i,
	input  wire logic [DATA_W-1:0] port_b_bus_i,
	output logic      [DATA_W-1:0] port_b_bus_o,
	output logic                   port_b_bus_oe_o,
	output logic                   ab_empty_n_o,
	output logic                   ab_almost_empty_n_o,
	output logic                   ab_almost_full_n_o,
	output logic                   ab_full_n_o,
	output logic                   ba_empty_n_o,
	output logic                   ba_almost_empty_n_o,
	output logic                   ba_almost_full_n_o,
	output logic                   ba_full_n_o,
	output logic                   port_b_bypass_ind_n_o,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [REG_W-1:0]  reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic      [REG_W-1:0]  reg_rdata_o
);

	// ****************************************************************
	// state
	// ****************************************************************

	typedef struct packed {
		logic [DATA_W-1:0]          pa_out;
		logic [DATA_W-1:0]          pb_out;
		logic [1:0][DATA_W-1:0]     byp_data;
		logic [1:0]                 byp_vld;
		logic [1:0]                 byp_empty_n;
		logic [1:0]                 byp_full_n;
		logic                       bypass;
		logic                       bypass_ind_n;
		// bypass mode as each port saw it on its own last tick
		logic [1:0]                 side_byp;
		logic [1:0][REG_W-1:0]      ae_off;
		logic [1:0][REG_W-1:0]      af_off;
		logic [REG_W-1:0]           rdata;
	} bfq_top_s;

	bfq_top_s state;
	bfq_top_s next_state;

	logic                   reset;
	logic [1:0]             port_clk;
	logic [1:0]             tick;
	logic [1:0]             port_en;
	logic [1:0]             port_wr;
	logic [1:0]             port_rd;
	logic [1:0][DATA_W-1:0] port_din;
	logic [1:0]             q_wr;
	logic [1:0]             q_rd;
	logic [1:0]             q_rd_ok;
	logic [1:0][DATA_W-1:0] q_head;
	logic [1:0]             q_empty_n;
	logic [1:0]             q_aempty_n;
	logic [1:0]             q_full_n;
	logic [1:0]             q_afull_n;
	logic [1:0]             empty_n;
	logic [1:0]             full_n;
	logic [1:0]             byp_wr_ok;
	logic [1:0]             byp_rd_ok;
	logic [REG_W-1:0]       status;

	// either reset source resets everything, offsets back to 8
	assign reset = rst_i | ~global_reset_n_i; // R16

	// ****************************************************************
	// per-port request decode
	// ****************************************************************

	assign port_clk[0] = port_a_clk_i;
	assign port_clk[1] = port_b_clk_i;
	assign port_en[0]  = ~port_a_xfer_enable_n_i;
	assign port_en[1]  = ~port_b_xfer_enable_n_i; // R1
	assign port_din[0] = port_a_bus_i;
	assign port_din[1] = port_b_bus_i;

	// transfers only on a port clock rising edge, steered by direction
	assign port_wr[0] = tick[0] & port_en[0] & (port_a_dir_i == DIR_WRITE);
	assign port_rd[0] = tick[0] & port_en[0] & (port_a_dir_i == DIR_READ);
	assign port_wr[1] = tick[1] & port_en[1] & (port_b_dir_i == DIR_WRITE); // R1 R17
	assign port_rd[1] = tick[1] & port_en[1] & (port_b_dir_i == DIR_READ); // R1 R17

	// ****************************************************************
	// per-direction queue and bypass path
	// ****************************************************************

	// direction d is written by port d and read by the other port
	for (genvar d = 0; d < 2; d++) begin : g_dir
		bfq_edge u_edge (
			.clk_sys_i (clk_sys_i),
			.rst_i     (reset),
			.level_i   (port_clk[d]),
			.rise_o    (tick[d])
		);

		assign q_wr[d] = port_wr[d] & ~state.side_byp[d];
		assign q_rd[d] = port_rd[1-d] & ~state.side_byp[1-d];

		// a bypass message is taken only once the previous one was read
		assign byp_wr_ok[d] = port_wr[d] & state.side_byp[d] & state.byp_full_n[d]; // R8 R14
		assign byp_rd_ok[d] = port_rd[1-d] & state.side_byp[1-d] & state.byp_empty_n[d]; // R18

		bfq_queue u_queue (
			.clk_sys_i        (clk_sys_i),
			.rst_i            (reset),
			.wr_i             (q_wr[d]),
			.rd_i             (q_rd[d]),
			.wr_tick_i        (tick[d]),
			.rd_tick_i        (tick[1-d]),
			.data_i           (port_din[d]),
			.ae_off_i         (state.ae_off[d]),
			.af_off_i         (state.af_off[d]),
			.wr_ok_o          (),
			.rd_ok_o          (q_rd_ok[d]),
			.head_o           (q_head[d]),
			.empty_n_o        (q_empty_n[d]),
			.almost_empty_n_o (q_aempty_n[d]),
			.full_n_o         (q_full_n[d]),
			.almost_full_n_o  (q_afull_n[d])
		);

		// pins switch source only on their own port's tick, never mid-cycle
		assign empty_n[d] = state.side_byp[1-d] ? state.byp_empty_n[d] : q_empty_n[d]; // R4 R10
		assign full_n[d]  = state.side_byp[d] ? state.byp_full_n[d] : q_full_n[d]; // R8 R14
	end

	// ****************************************************************
	// next state
	// ****************************************************************

	always_comb begin
		next_state = state;

		for (int d = 0; d < 2; d++) begin
			if (byp_wr_ok[d]) begin
				next_state.byp_data[d] = port_din[d];
				next_state.byp_vld[d]  = 1'b1;
			end else if (byp_rd_ok[d]) begin
				next_state.byp_vld[d] = 1'b0;
			end
			if (tick[d]) begin
				next_state.side_byp[d] = state.bypass;
			end
			// leaving bypass drops any unread message
			if (!state.bypass) begin
				next_state.byp_vld[d] = 1'b0;
			end
			// each bypass flag moves on its own port's clock edge
			if (tick[1-d]) begin
				next_state.byp_empty_n[d] = next_state.byp_vld[d]; // R4 R10
			end
			if (tick[d]) begin
				next_state.byp_full_n[d] = ~next_state.byp_vld[d]; // R8 R14
			end
		end

		// port A output register takes B-to-A data on an accepted read
		if (byp_rd_ok[DIR_BA]) begin
			next_state.pa_out = state.byp_data[DIR_BA];
		end else if (q_rd_ok[DIR_BA]) begin
			next_state.pa_out = q_head[DIR_BA];
		end

		// port B output register takes A-to-B data on an accepted read
		if (byp_rd_ok[DIR_AB]) begin
			next_state.pb_out = state.byp_data[DIR_AB]; // R18
		end else if (q_rd_ok[DIR_AB]) begin
			next_state.pb_out = q_head[DIR_AB]; // R17
		end

		if (tick[1]) begin
			next_state.bypass_ind_n = ~state.bypass; // R15
		end

		// register port writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_AB_AE_OFF: next_state.ae_off[DIR_AB] = reg_wdata_i; // R5
				REG_AB_AF_OFF: next_state.af_off[DIR_AB] = reg_wdata_i; // R6
				REG_BA_AE_OFF: next_state.ae_off[DIR_BA] = reg_wdata_i; // R11
				REG_BA_AF_OFF: next_state.af_off[DIR_BA] = reg_wdata_i; // R12
				REG_CTRL:      next_state.bypass = reg_wdata_i[CTRL_BYPASS_BIT];
				default:       next_state.bypass = state.bypass;
			endcase
		end

		// register port reads: data stands in the next cycle only
		next_state.rdata = '0;
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_AB_AE_OFF: next_state.rdata = state.ae_off[DIR_AB];
				REG_AB_AF_OFF: next_state.rdata = state.af_off[DIR_AB];
				REG_BA_AE_OFF: next_state.rdata = state.ae_off[DIR_BA];
				REG_BA_AF_OFF: next_state.rdata = state.af_off[DIR_BA];
				REG_CTRL:      next_state.rdata = {8'h00, state.bypass};
				REG_STATUS:    next_state.rdata = status;
				default:       next_state.rdata = '0;
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************

	always_ff @(posedge clk_sys_i) begin
		if (reset) begin
			state                <= '0; // R16
			state.byp_full_n     <= 2'b11; // R19
			state.bypass_ind_n   <= 1'b1; // R19
			state.ae_off[DIR_AB] <= OFFSET_RST; // R5
			state.ae_off[DIR_BA] <= OFFSET_RST; // R11
			state.af_off[DIR_AB] <= OFFSET_RST; // R6
			state.af_off[DIR_BA] <= OFFSET_RST; // R12
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	always_comb begin
		status               = '0;
		status[ST_AB_EMPTY]  = empty_n[DIR_AB];
		status[ST_AB_AEMPTY] = q_aempty_n[DIR_AB];
		status[ST_AB_AFULL]  = q_afull_n[DIR_AB];
		status[ST_AB_FULL]   = full_n[DIR_AB];
		status[ST_BA_EMPTY]  = empty_n[DIR_BA];
		status[ST_BA_AEMPTY] = q_aempty_n[DIR_BA];
		status[ST_BA_AFULL]  = q_afull_n[DIR_BA];
		status[ST_BA_FULL]   = full_n[DIR_BA];
		status[ST_BYP_IND]   = state.bypass_ind_n;
	end

	assign port_a_bus_o = state.pa_out;
	assign port_b_bus_o = state.pb_out;

	// bus driven only when reading and output enable is low
	assign port_b_bus_oe_o = (port_b_dir_i == DIR_READ) & ~port_b_out_enable_n_i; // R2

	assign ab_empty_n_o        = empty_n[DIR_AB]; // R3
	assign ab_almost_empty_n_o = q_aempty_n[DIR_AB];
	assign ab_almost_full_n_o  = q_afull_n[DIR_AB];
	assign ab_full_n_o         = full_n[DIR_AB]; // R7
	assign ba_empty_n_o        = empty_n[DIR_BA]; // R9
	assign ba_almost_empty_n_o = q_aempty_n[DIR_BA];
	assign ba_almost_full_n_o  = q_afull_n[DIR_BA];
	assign ba_full_n_o         = full_n[DIR_BA]; // R13
	assign port_b_bypass_ind_n_o = state.bypass_ind_n;
	assign reg_rdata_o         = state.rdata;

endmodule : bfq_top

//--- sim/bfq_top_assertions.sv
/*
 * concurrent checks on the ports of bfq_top: flag update moments,
 * refused transfers, bus drive and reset values.
 * assumes a bind from the bench top; one clock, clk_sys_i.
 */
`timescale 1ns/100ps

module bfq_top_assertions import bfq_pkg::*; (
	input wire logic              clk_sys_i,
	input wire logic              rst_i,
	input wire logic              global_reset_n_i,
	input wire logic              port_a_clk_i,
	input wire logic              port_b_clk_i,
	input wire logic              port_a_dir_i,
	input wire logic [DATA_W-1:0] port_a_bus_o,
	input wire logic              port_b_xfer_enable_n_i,
	input wire logic              port_b_dir_i,
	input wire logic              port_b_out_enable_n_i,
	input wire logic [DATA_W-1:0] port_b_bus_o,
	input wire logic              port_b_bus_oe_o,
	input wire logic              ab_empty_n_o,
	input wire logic              ab_almost_empty_n_o,
	input wire logic              ab_almost_full_n_o,
	input wire logic              ab_full_n_o,
	input wire logic              ba_empty_n_o,
	input wire logic              ba_almost_empty_n_o,
	input wire logic              ba_almost_full_n_o,
	input wire logic              ba_full_n_o,
	input wire logic              port_b_bypass_ind_n_o
);
	// ******************************
	// properties
	// ******************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i || !global_reset_n_i);

	a_oe_from_dir: assert property (port_b_bus_oe_o == (port_b_dir_i && !port_b_out_enable_n_i))
		else $error("B bus drive enable wrong");
	a_ab_empty_tick: assert property (!$rose(port_b_clk_i) |=> $stable({ab_empty_n_o, ab_almost_empty_n_o}))
		else $error("A-to-B empty flags moved off a B tick");
	a_ab_full_tick: assert property (!$rose(port_a_clk_i) |=> $stable({ab_full_n_o, ab_almost_full_n_o}))
		else $error("A-to-B full flags moved off an A tick");
	a_ba_empty_tick: assert property (!$rose(port_a_clk_i) |=> $stable({ba_empty_n_o, ba_almost_empty_n_o}))
		else $error("B-to-A empty flags moved off an A tick");
	a_ba_full_tick: assert property (!$rose(port_b_clk_i)
		|=> $stable({ba_full_n_o, ba_almost_full_n_o, port_b_bypass_ind_n_o}))
		else $error("B side flags moved off a B tick");
	a_b_read_blocked: assert property ($rose(port_b_clk_i) && port_b_dir_i && !ab_empty_n_o |=> $stable(port_b_bus_o))
		else $error("B read taken while empty");
	a_a_read_blocked: assert property ($rose(port_a_clk_i) && port_a_dir_i && !ba_empty_n_o |=> $stable(port_a_bus_o))
		else $error("A read taken while empty");
	a_b_disabled: assert property ($rose(port_b_clk_i) && port_b_xfer_enable_n_i |=> $stable(port_b_bus_o))
		else $error("B transfer while disabled");
	a_reset_flags: assert property (disable iff (rst_i) !global_reset_n_i |=> {port_b_bypass_ind_n_o, ba_full_n_o,
		ba_almost_full_n_o, ba_almost_empty_n_o, ba_empty_n_o, ab_full_n_o, ab_almost_full_n_o,
		ab_almost_empty_n_o, ab_empty_n_o} == 9'h1cc)
		else $error("flags not at reset values");
endmodule : bfq_top_assertions

//--- sim/bfq_port_model.sv
/*
 * port A and port B master model: free-running port clocks and pins.
 * assumes port clock levels step on clk_sys_i edges; index 0 is A.
 */
`timescale 1ns/100ps

module bfq_port_model import bfq_pkg::*; (
	input  wire logic                   clk_sys_i,
	output logic      [1:0]             pclk_o,
	output logic      [1:0]             tick_o,
	output logic      [1:0]             en_n_o,
	output logic      [1:0]             dir_o,
	output logic      [1:0][DATA_W-1:0] bus_o
);
	logic [1:0] prev = 2'h3;
	int         cnt[2] = '{0, 0};

	initial begin
		pclk_o = 2'h0;
		en_n_o = 2'h3;
		dir_o  = 2'h0;
		bus_o  = '0;
	end
	// ******************************
	// clocks and transfers
	// ******************************
	// transfer lands on the sys edge that first sees the port clock high
	assign tick_o = pclk_o & ~prev;
	always @(posedge clk_sys_i) begin
		prev <= pclk_o;
		for (int p = 0; p < 2; p++) begin
			if (cnt[p] >= p + 1) begin
				cnt[p]    <= 0;
				pclk_o[p] <= ~pclk_o[p];
			end else begin
				cnt[p] <= cnt[p] + 1;
			end
		end
	end
	// idle tick first, so the flags looked at are fresh
	task automatic xfer(input int p, input logic dir, input logic en_n, input logic [DATA_W-1:0] d);
		@(posedge clk_sys_i);
		while (!tick_o[p]) @(posedge clk_sys_i);
		en_n_o[p] <= en_n;
		dir_o[p]  <= dir;
		bus_o[p]  <= (dir == DIR_WRITE) ? d : ~bus_o[p];
		@(posedge clk_sys_i);
		while (!tick_o[p]) @(posedge clk_sys_i);
		en_n_o[p] <= 1'b1;
		bus_o[p]  <= ~bus_o[p];
	endtask : xfer
endmodule : bfq_port_model

//--- sim/bfq_tb_top.sv
/*
 * self-checking bench of bfq_top: queue, bypass, register and reset runs.
 * assumes bfq_port_model as the port masters and the bound checker.
 */
`timescale 1ns/100ps

module bfq_tb_top import bfq_pkg::*;;
	logic                   clk_sys_i = 1'b0;
	logic                   rst_i = 1'b1;
	logic                   glob_rst_n = 1'b1;
	logic                   oe_n = 1'b1;
	logic [ADDR_W-1:0]      reg_addr = '0;
	logic [REG_W-1:0]       reg_wdata = '0;
	logic                   reg_wr = 1'b0;
	logic                   reg_rd = 1'b0;
	logic [1:0]             pclk, en_n, dir;
	logic [1:0][DATA_W-1:0] pbus;
	wire  [REG_W-1:0]       reg_rdata;
	wire  [DATA_W-1:0]      a_out, b_out;
	wire                    b_oe;
	wire  [8:0]             flags;
	logic [DATA_W-1:0]      q[2][$];
	logic [DATA_W-1:0]      msg[2], last[2];
	int                     off[4];
	bit                     mv[2], byp;
	int                     errors = 0, n_checks = 0, cyc = 0;
	logic [31:0]            seed = 32'hab2389e5;

	always #12.5 clk_sys_i = ~clk_sys_i;

	bfq_port_model pm_i (.clk_sys_i, .pclk_o(pclk), .tick_o(), .en_n_o(en_n), .dir_o(dir), .bus_o(pbus));
	bfq_top bfq_top_i (.clk_sys_i, .rst_i, .global_reset_n_i(glob_rst_n),
		.port_a_clk_i(pclk[0]), .port_b_clk_i(pclk[1]),
		.port_a_xfer_enable_n_i(en_n[0]), .port_a_dir_i(dir[0]), .port_a_bus_i(pbus[0]),
		.port_a_bus_o(a_out), .port_b_xfer_enable_n_i(en_n[1]), .port_b_dir_i(dir[1]),
		.port_b_out_enable_n_i(oe_n), .port_b_bus_i(b_oe ? b_out : pbus[1]),
		.port_b_bus_o(b_out), .port_b_bus_oe_o(b_oe),
		.ab_empty_n_o(flags[0]), .ab_almost_empty_n_o(flags[1]), .ab_almost_full_n_o(flags[2]),
		.ab_full_n_o(flags[3]), .ba_empty_n_o(flags[4]), .ba_almost_empty_n_o(flags[5]),
		.ba_almost_full_n_o(flags[6]), .ba_full_n_o(flags[7]), .port_b_bypass_ind_n_o(flags[8]),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata));

	// ******************************
	// model and helpers
	// ******************************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [8:0] exp_st();
		logic [8:0] s;
		int         c;
		for (int d = 0; d < 2; d++) begin
			c          = q[d].size();
			s[4*d]     = byp ? mv[d] : c != 0;
			s[4*d + 1] = c > off[2*d];
			s[4*d + 2] = c <= DEPTH - off[2*d + 1];
			s[4*d + 3] = byp ? !mv[d] : c != DEPTH;
		end
		s[8] = !byp;
		return s;
	endfunction : exp_st
	task automatic mdl_reset();
		q[0].delete();
		q[1].delete();
		off  = '{4{8}};
		mv   = '{0, 0};
		byp  = 1'b0;
		last = '{'0, '0};
	endtask : mdl_reset
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic reg_wr_t(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge clk_sys_i);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr    <= 1'b0;
	endtask : reg_wr_t
	task automatic reg_rd_t(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
		@(posedge clk_sys_i);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd   <= 1'b0;
		@(posedge clk_sys_i);
		chk(DATA_W'(reg_rdata), DATA_W'(e));
	endtask : reg_rd_t
	// one port transfer, then the flags of that port's side and its read register
	task automatic op(input int p, input logic rd, input logic dis);
		logic [DATA_W-1:0] d;
		logic [8:0]        m;
		d    = DATA_W'(xs());
		m    = p ? 9'h1c3 : 9'h03c;
		oe_n <= d[0];
		pm_i.xfer(p, rd, dis, d);
		if (!dis && rd == DIR_WRITE) begin
			if (byp && !mv[p]) begin
				msg[p] = d;
				mv[p]  = 1'b1;
			end else if (!byp && q[p].size() < DEPTH) begin
				q[p].push_back(d);
			end
		end else if (!dis && byp && mv[1-p]) begin
			last[p]  = msg[1-p];
			mv[1-p] = 1'b0;
		end else if (!dis && !byp && q[1-p].size() > 0) begin
			last[p] = q[1-p].pop_front();
		end
		@(posedge clk_sys_i);
		chk(DATA_W'(flags & m), DATA_W'(exp_st() & m));
		chk(p ? b_out : a_out, last[p]);
	endtask : op
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			give_verdict();
		end
	end

	// ******************************
	// scenarios
	// ******************************
	initial begin
		mdl_reset();
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		chk(DATA_W'(flags), DATA_W'(exp_st()));
		for (int a = 0; a < 8; a++) begin
			reg_rd_t(a[2:0], a < 4 ? OFFSET_RST : (a == 5 ? exp_st() : 9'h000));
		end
		reg_wr_t(3'h7, 9'h1ff);
		reg_wr_t(REG_STATUS, 9'h000);
		reg_rd_t(3'h7, 9'h000);
		reg_rd_t(REG_STATUS, exp_st());
		for (int a = 0; a < 4; a++) begin
			off[a] = int'(xs() % 257);
			reg_wr_t(a[2:0], off[a][8:0]);
			reg_rd_t(a[2:0], off[a][8:0]);
		end
		$display("reset and registers done");
		// fill past full, drain past empty, a disabled slot every ninth
		for (int w = 0; w < 2; w++) begin
			for (int i = 0; i < 290; i++) op(w, DIR_WRITE, i % 9 == 4);
			for (int i = 0; i < 290; i++) op(1 - w, DIR_READ, i % 9 == 4);
			$display("queue run %0d done", w);
		end
		reg_wr_t(REG_CTRL, 9'h001);
		byp = 1'b1;
		op(1, DIR_READ, 1'b0);
		for (int w = 0; w < 2; w++) begin
			op(w, DIR_WRITE, 1'b0);
			op(w, DIR_WRITE, 1'b0);
			op(1 - w, DIR_READ, 1'b1);
			op(1 - w, DIR_READ, 1'b0);
			op(1 - w, DIR_READ, 1'b0);
			op(w, DIR_WRITE, 1'b0);
		end
		// leaving bypass drops both pending messages
		reg_wr_t(REG_CTRL, 9'h000);
		byp = 1'b0;
		mv  = '{0, 0};
		op(1, DIR_READ, 1'b0);
		op(0, DIR_READ, 1'b0);
		$display("bypass done");
		op(0, DIR_WRITE, 1'b0);
		op(0, DIR_WRITE, 1'b0);
		@(posedge clk_sys_i);
		glob_rst_n <= 1'b0;
		@(posedge clk_sys_i);
		glob_rst_n <= 1'b1;
		mdl_reset();
		@(posedge clk_sys_i);
		chk(DATA_W'(flags), DATA_W'(exp_st()));
		reg_rd_t(REG_AB_AE_OFF, OFFSET_RST);
		op(1, DIR_READ, 1'b0);
		$display("global reset done");
		give_verdict();
	end
endmodule : bfq_tb_top

bind bfq_top bfq_top_assertions bfq_top_assertions_i (.clk_sys_i, .rst_i, .global_reset_n_i,
	.port_a_clk_i, .port_b_clk_i, .port_a_dir_i, .port_a_bus_o, .port_b_xfer_enable_n_i,
	.port_b_dir_i, .port_b_out_enable_n_i, .port_b_bus_o, .port_b_bus_oe_o, .ab_empty_n_o,
	.ab_almost_empty_n_o, .ab_almost_full_n_o, .ab_full_n_o, .ba_empty_n_o, .ba_almost_empty_n_o,
	.ba_almost_full_n_o, .ba_full_n_o, .port_b_bypass_ind_n_o);
